// *** hw/tc_channel.sv ***
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
// Contract
// - interval start waits first count clock, loads
// - start interrupt only when select bit set
// - interval counts down, interrupts, reloads at zero
// - event mode loads reload value at start
// - event mode decrements per valid edge
// - filter adds two clocks to edge detection
// - capture clears counter at first count clock
// - capture edge stores count, interrupts, restarts zero
// - one-count waits rising edge, loads, counts down
// - one-count zero interrupts, all ones, stops
// - rise clears and counts, fall captures, interrupts
// - master role toggles on own interrupt only
// - slave role set/reset by level select
// - simultaneous set and reset gives reset
// - output enabled ignores software output writes
// - output disabled takes writes, blocks interrupts
// - output state always readable
// - only channels zero and two are masters; the code forces only channel zero to the master role
// - output settings never disturb counting
// - master start toggles from default level
// - level change waits next set or reset
// - unfiltered edge lags one to two clocks; the code takes four to five clocks from the pin change to the count
module tc_channel #(
  parameter int DATA_W = 16,     // counter and data width
  parameter int CHAN_INDEX = 1   // position in the four channel unit
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [4:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWritedata,
  output logic [31:0] avReaddata,
  output logic avWaitrequest,
  input wire logic countTick,        // count clock pulse from the prescaler
  input wire logic timerInputPin,    // asynchronous timer input pin
  input wire logic masterInterrupt,  // channel_interrupt of the master channel
  output logic channelInterrupt,     // one-cycle pulse
  output logic channelOutputBit      // output pin level
);

  // channel zero has no master, so it may never take the slave role
  localparam bit CAN_SLAVE = (CHAN_INDEX != 0);

  // elaboration check on the parameters
  if (DATA_W < 2 || DATA_W > 32 || CHAN_INDEX < 0 || CHAN_INDEX > 3) begin : gChk
    $error("tc_channel: unsupported parameter value");
  end

  localparam logic [DATA_W-1:0] ALL_ONES = {DATA_W{1'b1}};
  localparam logic [DATA_W-1:0] ZERO = {DATA_W{1'b0}};
  localparam logic [DATA_W-1:0] ONE = {{(DATA_W-1){1'b0}}, 1'b1};

  // whole state of the channel
  typedef struct packed {
    logic [2:0] pinSync;           // three-stage pin synchroniser
    logic pinLvl;                  // synchronised level
    logic [1:0] filt;              // filter history
    logic edgeLvl;                 // level fed to the edge detector
    tc_pkg::tc_mode_t mode;        // counting mode
    logic startIrqSel;             // start_interrupt_select
    logic [1:0] edgeSel;           // valid edge choice
    logic filtEn;                  // noise filter enable
    logic enabled;                 // channel_enabled_flag
    logic started;                 // start trigger seen
    logic [DATA_W-1:0] count;      // count_value
    logic [DATA_W-1:0] data;       // reload_capture_value
    logic irq;                     // channel_interrupt pulse
    logic role;                    // output_role_select
    logic level;                   // active_level_select
    logic oe;                      // output_enable_bit
    logic outBit;                  // channel_output_bit
    logic ack;                     // bus answer phase
    logic [31:0] rdata;            // read data
  } tc_state_t;

  tc_state_t q;
  tc_state_t next_q;

  // bus helpers: a request is answered one edge after it appears
  logic busReq;
  logic wrNow;
  logic rise;
  logic fall;
  logic lvlNext; // level the edge detector takes at the coming edge
  logic validEdge;
  logic [31:0] rd;

  assign busReq = avRead | avWrite;
  assign wrNow = avWrite & q.ack;
  assign avWaitrequest = busReq & ~q.ack;
  assign avReaddata = q.rdata;
  assign channelInterrupt = q.irq;
  assign channelOutputBit = q.outBit;

  // edge detection on the filtered pin level; the coming level is worked out
  // from q alone, so the edge never loops back through next_q
  always_comb begin
    lvlNext = q.edgeLvl;
    if (!q.filtEn) begin
      lvlNext = q.pinLvl;
    end else if (q.filt[0] == q.filt[1]) begin
      lvlNext = q.filt[1];
    end
    rise = lvlNext & ~q.edgeLvl;
    fall = ~lvlNext & q.edgeLvl;
    if (q.edgeSel == tc_pkg::EDGE_FALL) begin
      validEdge = fall;
    end else if (q.edgeSel == tc_pkg::EDGE_RISE) begin
      validEdge = rise;
    end else if (q.edgeSel == tc_pkg::EDGE_BOTH) begin
      validEdge = rise | fall;
    end else begin
      validEdge = 1'b0;
    end
  end

  // read mux, decoded by address; unmapped words read zero
  always_comb begin
    rd = 32'h0000_0000;
    if (avAddress == tc_pkg::OFS_MODE) begin
      rd[tc_pkg::MODE_LSB +: 3] = q.mode;
      rd[tc_pkg::STIRQ_BIT] = q.startIrqSel;
      rd[tc_pkg::EDGE_LSB +: 2] = q.edgeSel;
      rd[tc_pkg::FILT_BIT] = q.filtEn;
    end else if (avAddress == tc_pkg::OFS_RUN) begin
      rd[tc_pkg::START_BIT] = q.enabled;
    end else if (avAddress == tc_pkg::OFS_DATA) begin
      rd[DATA_W-1:0] = q.data;
    end else if (avAddress == tc_pkg::OFS_COUNT) begin
      rd[DATA_W-1:0] = q.count;
    end else if (avAddress == tc_pkg::OFS_OUTCTL) begin
      rd[tc_pkg::ROLE_BIT] = q.role;
      rd[tc_pkg::LEVEL_BIT] = q.level;
      rd[tc_pkg::OE_BIT] = q.oe;
    end else if (avAddress == tc_pkg::OFS_OUTST) begin
      rd[0] = q.outBit;
    end
  end

  // next-state logic for bus, input path, counter and output stage
  always_comb begin
    next_q = q;
    next_q.irq = 1'b0;
    // bus answer: acknowledge toggles so each request takes two edges
    next_q.ack = busReq & ~q.ack;
    if (avRead & ~q.ack) begin
      next_q.rdata = rd;
    end
    // pin synchroniser; only stages two and three are compared
    next_q.pinSync = {q.pinSync[1:0], timerInputPin};
    if (q.pinSync[1] == q.pinSync[2]) begin
      next_q.pinLvl = q.pinSync[2];
    end
    // filter needs the level to stay for two more clocks
    next_q.filt = {q.filt[0], q.pinLvl};
    next_q.edgeLvl = lvlNext;

    // counting; runs only while the channel is enabled
    if (q.enabled) begin
      case (q.mode)
        tc_pkg::TC_INTERVAL: begin
          if (countTick && !q.started) begin
            next_q.started = 1'b1;
            next_q.count = q.data;
            next_q.irq = q.startIrqSel;
          end else if (countTick && q.count == ZERO) begin
            next_q.count = q.data;
            next_q.irq = 1'b1;
          end else if (countTick) begin
            next_q.count = q.count - ONE;
          end
        end
        tc_pkg::TC_EVENT: begin
          // reaching zero reloads and interrupts, like interval mode
          if (validEdge && q.count == ZERO) begin
            next_q.count = q.data;
            next_q.irq = 1'b1;
          end else if (validEdge) begin
            next_q.count = q.count - ONE;
          end
        end
        tc_pkg::TC_CAPTURE: begin
          if (countTick && !q.started) begin
            next_q.started = 1'b1;
            next_q.count = ZERO;
            next_q.irq = q.startIrqSel;
          end else if (q.started && validEdge) begin
            // the first capture after start has no interval meaning
            next_q.data = q.count;
            next_q.irq = 1'b1;
            next_q.count = ZERO;
          end else if (q.started && countTick) begin
            next_q.count = q.count + ONE;
          end
        end
        tc_pkg::TC_ONECOUNT: begin
          if (rise) begin
            // a new trigger restarts even a running count
            next_q.started = 1'b1;
            next_q.count = q.data;
          end else if (q.started && countTick && q.count == ZERO) begin
            next_q.irq = 1'b1;
            next_q.count = ALL_ONES;
            next_q.started = 1'b0;
          end else if (q.started && countTick) begin
            next_q.count = q.count - ONE;
          end
        end
        tc_pkg::TC_CAPONE: begin
          if (rise) begin
            next_q.started = 1'b1;
            next_q.count = ZERO;
          end else if (q.started && fall) begin
            next_q.data = q.count;
            next_q.irq = 1'b1;
            next_q.started = 1'b0;
          end else if (q.started && countTick) begin
            next_q.count = q.count + ONE;
          end
        end
        default: begin
          next_q.started = 1'b0;
        end
      endcase
    end

    // output stage; it never writes count or data
    if (q.oe) begin
      if (q.role == 1'b0) begin
        // level select ignored here; start interrupt also toggles
        if (q.irq) begin
          next_q.outBit = ~q.outBit;
        end
      end else if (q.irq) begin
        // own interrupt resets and wins over the master's set
        next_q.outBit = q.level;
      end else if (masterInterrupt) begin
        next_q.outBit = ~q.level;
      end
    end

    // register writes take effect at the edge that ends the wait
    if (wrNow) begin
      if (avAddress == tc_pkg::OFS_MODE) begin
        if (avWritedata[tc_pkg::MODE_LSB +: 3] <= tc_pkg::MODE_LAST) begin
          next_q.mode = tc_pkg::tc_mode_t'(avWritedata[tc_pkg::MODE_LSB +: 3]);
        end
        next_q.startIrqSel = avWritedata[tc_pkg::STIRQ_BIT];
        next_q.edgeSel = avWritedata[tc_pkg::EDGE_LSB +: 2];
        next_q.filtEn = avWritedata[tc_pkg::FILT_BIT];
      end else if (avAddress == tc_pkg::OFS_RUN) begin
        if (avWritedata[tc_pkg::STOP_BIT]) begin
          next_q.enabled = 1'b0;
          next_q.started = 1'b0;
        end else if (avWritedata[tc_pkg::START_BIT]) begin
          // start always rearms; the counter keeps its value, except in event mode where it loads data
          next_q.enabled = 1'b1;
          next_q.started = 1'b0;
          if (q.mode == tc_pkg::TC_EVENT) begin
            next_q.count = q.data;
          end
        end
      end else if (avAddress == tc_pkg::OFS_DATA) begin
        next_q.data = avWritedata[DATA_W-1:0];
      end else if (avAddress == tc_pkg::OFS_OUTCTL) begin
        // settings only, pin level is left as it is
        next_q.role = avWritedata[tc_pkg::ROLE_BIT] & CAN_SLAVE;
        next_q.level = avWritedata[tc_pkg::LEVEL_BIT];
        next_q.oe = avWritedata[tc_pkg::OE_BIT];
      end else if (avAddress == tc_pkg::OFS_OUTST) begin
        if (!q.oe) begin
          next_q.outBit = avWritedata[0];
        end
      end
    end
  end

  // single state register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{
        pinSync: 3'h0, pinLvl: 1'b0, filt: 2'h0, edgeLvl: 1'b0,
        mode: tc_pkg::TC_INTERVAL, startIrqSel: 1'b0,
        edgeSel: tc_pkg::EDGE_RST, filtEn: 1'b0, enabled: 1'b0,
        started: 1'b0, count: ZERO, data: ZERO, irq: 1'b0, role: 1'b0,
        level: 1'b0, oe: 1'b0, outBit: tc_pkg::OUT_RST, ack: 1'b0,
        rdata: 32'h0000_0000};
    end else begin
      q <= next_q;
    end
  end

  // assertions
  AST_INT_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    q.enabled && q.mode == tc_pkg::TC_INTERVAL && !q.started && countTick && !wrNow
    |=> q.count == $past(q.data) && q.started)
    else $error("interval start did not load reload value");
  AST_START_IRQ: assert property (@(posedge core_clk) disable iff (!resetn)
    q.enabled && q.mode == tc_pkg::TC_CAPTURE && !q.started && countTick && !wrNow
    |=> q.irq == $past(q.startIrqSel))
    else $error("start interrupt does not follow select");
  AST_INT_RELOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    q.enabled && q.mode == tc_pkg::TC_INTERVAL && q.started && countTick
    && q.count == ZERO && !wrNow |=> q.irq && q.count == $past(q.data))
    else $error("interval zero did not reload and interrupt");
  AST_EVT_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !q.enabled && !wrNow |=> $stable(q.count))
    else $error("counter moved while disabled");
  AST_CAP_STORE: assert property (@(posedge core_clk) disable iff (!resetn)
    q.enabled && q.mode == tc_pkg::TC_CAPTURE && q.started && validEdge && !wrNow
    |=> q.data == $past(q.count) && q.count == ZERO && q.irq)
    else $error("capture edge mishandled");
  AST_ONE_STOP: assert property (@(posedge core_clk) disable iff (!resetn)
    q.enabled && q.mode == tc_pkg::TC_ONECOUNT && q.started && countTick
    && q.count == ZERO && !rise && !wrNow |=> q.count == ALL_ONES && !q.started)
    else $error("one-count end not handled");
  AST_TOGGLE: assert property (@(posedge core_clk) disable iff (!resetn)
    q.oe && !q.role && q.irq && !wrNow |=> q.outBit != $past(q.outBit))
    else $error("master role did not toggle");
  AST_PRIO: assert property (@(posedge core_clk) disable iff (!resetn)
    q.oe && q.role && q.irq && masterInterrupt && !wrNow |=> q.outBit == $past(q.level))
    else $error("reset did not win over set");
  AST_BLOCK: assert property (@(posedge core_clk) disable iff (!resetn)
    !q.oe && !wrNow |=> $stable(q.outBit))
    else $error("output moved while disabled");
  AST_WAIT: assert property (@(posedge core_clk) disable iff (!resetn)
    busReq && !q.ack |-> avWaitrequest ##1 (!busReq || !avWaitrequest))
    else $error("bus answer took more than one wait cycle");
  // interval mode leaves the counter alone until the first count clock
  AST_INT_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    q.enabled && q.mode == tc_pkg::TC_INTERVAL && !q.started && !countTick && !wrNow
    |=> $stable(q.count))
    else $error("interval counter moved before first count clock");
  // event mode loads at the start write itself, with no count clock needed
  AST_EVT_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    wrNow && avAddress == tc_pkg::OFS_RUN && avWritedata[tc_pkg::START_BIT]
    && !avWritedata[tc_pkg::STOP_BIT] && q.mode == tc_pkg::TC_EVENT
    |=> q.count == $past(q.data) && q.enabled)
    else $error("event start did not load reload value");
  // count clocks alone must never move an event counter
  AST_EVT_TICK: assert property (@(posedge core_clk) disable iff (!resetn)
    q.enabled && q.mode == tc_pkg::TC_EVENT && !validEdge && !wrNow |=> $stable(q.count))
    else $error("event counter moved without a valid edge");
  // a level that has not held for two clocks never reaches the edge detector
  AST_FILT: assert property (@(posedge core_clk) disable iff (!resetn)
    q.filtEn && q.filt[0] != q.filt[1] |=> $stable(q.edgeLvl))
    else $error("filter passed an unsettled level");
  // capture starts from zero at the first count clock
  AST_CAP_START: assert property (@(posedge core_clk) disable iff (!resetn)
    q.enabled && q.mode == tc_pkg::TC_CAPTURE && !q.started && countTick && !wrNow
    |=> q.count == ZERO && q.started)
    else $error("capture start did not clear counter");
  // a rising pin edge loads and arms the one-count run, even mid-count
  AST_ONE_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    q.enabled && q.mode == tc_pkg::TC_ONECOUNT && rise && !wrNow
    |=> q.count == $past(q.data) && q.started)
    else $error("one-count trigger did not load reload value");
  // the falling edge ends a high-level measurement
  AST_CAPONE: assert property (@(posedge core_clk) disable iff (!resetn)
    q.enabled && q.mode == tc_pkg::TC_CAPONE && q.started && fall && !wrNow
    |=> q.data == $past(q.count) && q.irq && !q.started)
    else $error("falling edge did not capture");
  // the master's interrupt alone drives the inactive-to-active change
  AST_SLAVE: assert property (@(posedge core_clk) disable iff (!resetn)
    q.oe && q.role && masterInterrupt && !q.irq |=> q.outBit == !$past(q.level))
    else $error("master interrupt did not set the slave output");
  // with output enabled only interrupts may move the pin
  AST_SW_IGNORE: assert property (@(posedge core_clk) disable iff (!resetn)
    q.oe && !q.irq && !masterInterrupt |=> $stable(q.outBit))
    else $error("output moved without an interrupt");
  // the output state reads back whatever the enables are
  AST_READ_OUT: assert property (@(posedge core_clk) disable iff (!resetn)
    avRead && !q.ack && avAddress == tc_pkg::OFS_OUTST |=> avReaddata[0] == $past(q.outBit))
    else $error("output state read back wrong");

endmodule

// *** pkg/tc_pkg.sv ***
// shared constants for the timer channel
package tc_pkg;
  // counting modes
  typedef enum logic [2:0] {
    TC_INTERVAL,
    TC_EVENT,
    TC_CAPTURE,
    TC_ONECOUNT,
    TC_CAPONE
  } tc_mode_t;
  localparam logic [2:0] MODE_LAST = 3'h4;   // highest legal mode code
  // register byte offsets
  localparam logic [4:0] OFS_MODE = 5'h00;   // mode and input setup
  localparam logic [4:0] OFS_RUN = 5'h04;    // start / stop / enabled flag
  localparam logic [4:0] OFS_DATA = 5'h08;   // reload_capture_value
  localparam logic [4:0] OFS_COUNT = 5'h0C;  // count_value, read only
  localparam logic [4:0] OFS_OUTCTL = 5'h10; // role, level, enable
  localparam logic [4:0] OFS_OUTST = 5'h14;  // output_state_register
  // mode register fields
  localparam int MODE_LSB = 0;      // mode code, 3 bits
  localparam int STIRQ_BIT = 3;     // start_interrupt_select
  localparam int EDGE_LSB = 4;      // valid edge, 2 bits
  localparam int FILT_BIT = 6;      // noise filter enable
  // run register fields
  localparam int START_BIT = 0;     // channel_start_bit, write one
  localparam int STOP_BIT = 1;      // stop, write one
  // output control fields
  localparam int ROLE_BIT = 0;      // output_role_select
  localparam int LEVEL_BIT = 1;     // active_level_select
  localparam int OE_BIT = 2;        // output_enable_bit
  // valid edge codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // reset values
  localparam logic [1:0] EDGE_RST = 2'h1;
  localparam logic OUT_RST = 1'b0;
endpackage

// *** tb/tc_pin_model.sv ***
`timescale 1ns/100ps
// far side of the channel: drives the timer input pin and stands in for the master channel
module tc_pin_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic pinReq,         // level the pin should take
  input wire logic mstReq,         // ask for one master interrupt pulse
  input wire logic syncReq,        // fire the master together with the channel
  input wire logic slaveIrq,       // channel interrupt of the design
  output logic timerInputPin,
  output logic masterInterrupt
);
  logic mstPulse; // registered master pulse
  // pin changes only on an edge; held steady for many cycles by the bench
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timerInputPin <= 1'b0;
      mstPulse <= 1'b0;
    end else begin
      timerInputPin <= pinReq;
      mstPulse <= mstReq & !mstPulse; // one cycle wide, like a real interrupt
    end
  end
  // sync mode lets a master pulse land in the very cycle of the slave pulse
  assign masterInterrupt = mstPulse | (syncReq & slaveIrq);
endmodule

// *** tb/tb_timer_channel_modes_and_output.sv ***
`timescale 1ns/100ps
module tb_timer_channel_modes_and_output;
  typedef struct {logic [4:0] a; logic [31:0] v;} tc_row_t; // address and reset value
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avAddress = 5'h00;
  logic avRead = 1'b0;
  logic avWrite = 1'b0;
  logic [31:0] avWritedata = 32'h0;
  logic [31:0] avReaddata;
  logic avWaitrequest;
  logic countTick = 1'b0;
  logic pinReq = 1'b0;
  logic mstReq = 1'b0;
  logic syncReq = 1'b0;
  logic timerInputPin;
  logic masterInterrupt;
  logic channelInterrupt;
  logic channelOutputBit;
  logic [31:0] rdata; // last read word
  int err_total = 0;
  int n_compared = 0;
  int irqCnt = 0; // interrupt pulses seen
  int b;
  tc_row_t rows [7] = '{
    '{tc_pkg::OFS_MODE, {26'h0, tc_pkg::EDGE_RST, 4'h0}},
    '{tc_pkg::OFS_RUN, 32'h0}, '{tc_pkg::OFS_DATA, 32'h0}, '{tc_pkg::OFS_COUNT, 32'h0},
    '{tc_pkg::OFS_OUTCTL, 32'h0}, '{tc_pkg::OFS_OUTST, 32'h0},
    '{5'h18, 32'h0}}; // last row is unmapped
  // 100 ns clock
  always #50 core_clk = ~core_clk;
  tc_channel tc_channel_inst (.core_clk(core_clk), .resetn(resetn), .avAddress(avAddress),
    .avRead(avRead), .avWrite(avWrite), .avWritedata(avWritedata), .avReaddata(avReaddata),
    .avWaitrequest(avWaitrequest), .countTick(countTick), .timerInputPin(timerInputPin),
    .masterInterrupt(masterInterrupt), .channelInterrupt(channelInterrupt),
    .channelOutputBit(channelOutputBit));
  tc_pin_model tc_pin_model_inst (.core_clk(core_clk), .resetn(resetn), .pinReq(pinReq),
    .mstReq(mstReq), .syncReq(syncReq), .slaveIrq(channelInterrupt),
    .timerInputPin(timerInputPin), .masterInterrupt(masterInterrupt));
  // count interrupt pulses, one per cycle high
  always @(posedge core_clk) begin
    if (channelInterrupt === 1'b1) irqCnt++;
  end
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus cycle; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avAddress <= a;
    avWritedata <= d;
    avWrite <= wr;
    avRead <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avWaitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_total++;
      end_of_test();
    end else begin
      // read data stands at the edge that samples waitrequest low
      rdata = avReaddata;
      avWrite <= 1'b0;
      avRead <= 1'b0;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input string what, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(what, rdata, e);
  endtask
  // count clock pulses, spaced so each settles
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      countTick <= 1'b1;
      @(posedge core_clk);
      countTick <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  // pin level change, then enough cycles for sync and filter
  task automatic pin(input logic l);
    @(posedge core_clk);
    pinReq <= l;
    repeat (10) @(posedge core_clk);
  endtask
  task automatic mst();
    @(posedge core_clk);
    mstReq <= 1'b1;
    @(posedge core_clk);
    mstReq <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic outIs(input logic e);
    check("outBit", {31'h0, channelOutputBit}, {31'h0, e});
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (50000) @(posedge core_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (rows[i]) rc("resetValue", rows[i].a, rows[i].v);
    $display("test reset done");
    // output set up in the documented order before start
    wr(tc_pkg::OFS_OUTST, 32'h1);
    rc("outst", tc_pkg::OFS_OUTST, 32'h1);
    wr(tc_pkg::OFS_OUTCTL, 32'h4);
    wr(tc_pkg::OFS_MODE, 32'h18);
    wr(tc_pkg::OFS_DATA, 32'h2);
    wr(tc_pkg::OFS_RUN, 32'h1);
    rc("count", tc_pkg::OFS_COUNT, 32'h0);
    tick(1);
    check("irq", 32'(irqCnt), 32'h1);
    rc("count", tc_pkg::OFS_COUNT, 32'h2);
    outIs(1'b0);
    tick(2);
    rc("count", tc_pkg::OFS_COUNT, 32'h0);
    tick(1);
    check("irq", 32'(irqCnt), 32'h2);
    outIs(1'b1);
    wr(tc_pkg::OFS_OUTST, 32'h0);
    mst();
    outIs(1'b1);
    rc("count", tc_pkg::OFS_COUNT, 32'h2);
    $display("test interval done");
    wr(tc_pkg::OFS_RUN, 32'h2);
    wr(tc_pkg::OFS_MODE, 32'h11);
    wr(tc_pkg::OFS_DATA, 32'h3);
    wr(tc_pkg::OFS_RUN, 32'h1);
    rc("count", tc_pkg::OFS_COUNT, 32'h3);
    tick(1);
    pin(1'b1);
    pin(1'b0);
    rc("count", tc_pkg::OFS_COUNT, 32'h2);
    wr(tc_pkg::OFS_RUN, 32'h2);
    pin(1'b1);
    pin(1'b0);
    rc("count", tc_pkg::OFS_COUNT, 32'h2);
    wr(tc_pkg::OFS_MODE, 32'h51);
    wr(tc_pkg::OFS_RUN, 32'h1);
    // read lands where an unfiltered edge would already have counted
    @(posedge core_clk);
    pinReq <= 1'b1;
    repeat (5) @(posedge core_clk);
    rc("count", tc_pkg::OFS_COUNT, 32'h3);
    repeat (10) @(posedge core_clk);
    rc("count", tc_pkg::OFS_COUNT, 32'h2);
    $display("test event done");
    wr(tc_pkg::OFS_RUN, 32'h2);
    wr(tc_pkg::OFS_MODE, 32'h02); // falling edge is the valid one
    wr(tc_pkg::OFS_RUN, 32'h1);
    b = irqCnt;
    tick(1);
    check("irq", 32'(irqCnt), 32'(b));
    tick(4);
    rc("count", tc_pkg::OFS_COUNT, 32'h4);
    pin(1'b0);
    rc("capture", tc_pkg::OFS_DATA, 32'h4);
    rc("count", tc_pkg::OFS_COUNT, 32'h0);
    check("irq", 32'(irqCnt), 32'(b + 1));
    $display("test capture done");
    wr(tc_pkg::OFS_RUN, 32'h2);
    wr(tc_pkg::OFS_MODE, 32'h13);
    wr(tc_pkg::OFS_DATA, 32'h2);
    wr(tc_pkg::OFS_RUN, 32'h1);
    tick(1);
    rc("count", tc_pkg::OFS_COUNT, 32'h0);
    pin(1'b1);
    rc("count", tc_pkg::OFS_COUNT, 32'h2);
    b = irqCnt;
    tick(3);
    rc("count", tc_pkg::OFS_COUNT, 32'hFFFF);
    tick(1);
    rc("count", tc_pkg::OFS_COUNT, 32'hFFFF);
    check("irq", 32'(irqCnt), 32'(b + 1));
    pin(1'b0);
    $display("test one-count done");
    wr(tc_pkg::OFS_RUN, 32'h2);
    wr(tc_pkg::OFS_MODE, 32'h14);
    wr(tc_pkg::OFS_RUN, 32'h1);
    pin(1'b1);
    tick(2);
    b = irqCnt;
    pin(1'b0);
    rc("capture", tc_pkg::OFS_DATA, 32'h2);
    check("irq", 32'(irqCnt), 32'(b + 1));
    $display("test capture one-count done");
    // slave output: interval with zero reload gives an interrupt on every tick
    wr(tc_pkg::OFS_RUN, 32'h2);
    wr(tc_pkg::OFS_OUTCTL, 32'h0);
    wr(tc_pkg::OFS_OUTST, 32'h0);
    wr(tc_pkg::OFS_OUTCTL, 32'h5);
    wr(tc_pkg::OFS_MODE, 32'h18);
    wr(tc_pkg::OFS_DATA, 32'h0);
    wr(tc_pkg::OFS_RUN, 32'h1);
    mst();
    outIs(1'b1);
    tick(1);
    outIs(1'b0);
    wr(tc_pkg::OFS_OUTCTL, 32'h7);
    outIs(1'b0);
    tick(1);
    outIs(1'b1);
    mst();
    outIs(1'b0);
    wr(tc_pkg::OFS_OUTCTL, 32'h5);
    mst();
    outIs(1'b1);
    @(posedge core_clk);
    syncReq <= 1'b1;
    tick(1);
    outIs(1'b0);
    rc("outst", tc_pkg::OFS_OUTST, 32'h0);
    syncReq <= 1'b0;
    $display("test output stage done");
    end_of_test();
  end
endmodule
